// [verilog/spwoc_top.sv]
// module: wired-or combiner of eight cores onto 32 shared pins, apb slave
// Operation
// - each core owns a 32-bit direction and a 32-bit output register
// - pin direction is the or of all cores' direction bits
// - core contribution is (output or internal sources) and own direction
// - pin level is the or of all cores' masked contributions
// - direction bit one means output, zero means input
// - a stopped core has direction and contribution forced to zero
// - input pseudo register reads live synchronised pin levels
// - 32 pins; pins 28..31 reserved for boot, general afterwards
// - shutdown halts all cores and turns every pin into an input
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module spwoc_top #(
    parameter int NUM_CORES = spwoc_pkg::NUM_CORES,
    parameter int NUM_PINS = spwoc_pkg::NUM_PINS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // internal i/o sources of each core (counters, video), same clock
    input wire logic [NUM_CORES*NUM_PINS-1:0] core_src,
    // shared pins
    input wire logic [NUM_PINS-1:0] pin_i,
    output logic [NUM_PINS-1:0] pin_o,
    output logic [NUM_PINS-1:0] pin_oe_n,
    // boot pin ownership
    input wire logic [3:0] boot_pin_o,
    input wire logic [3:0] boot_pin_oe_n,
    // status
    output logic [NUM_CORES-1:0] core_running
);
    // short aliases keep the loops readable
    localparam int NC = NUM_CORES;
    localparam int NP = NUM_PINS;

    // per core registers, run mask and global control
    logic [NP-1:0] dir_q [NC];
    logic [NP-1:0] dir_d [NC];
    logic [NP-1:0] out_q [NC];
    logic [NP-1:0] out_d [NC];
    logic [NC-1:0] run_q;
    logic [NC-1:0] run_d;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    // bus answer registers
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    // pin output registers
    logic [NP-1:0] pin_o_q;
    logic [NP-1:0] pin_o_d;
    logic [NP-1:0] pin_oe_n_q;
    logic [NP-1:0] pin_oe_n_d;

    // decode and status nets
    logic [NP-1:0] pins_live;
    logic shutdown;
    logic boot_mode;
    logic setup;
    logic [3:0] core_idx;
    logic [3:0] reg_off;
    logic core_hit;

    spwoc_sync_if #(.W(NP)) sif ();

    // three stages cost latency but keep metastable levels off the read path
    // raw pins pass the synchroniser before software sees them
    assign sif.raw = pin_i;
    assign pins_live = sif.clean;

    spwoc_sync #(.W(NP)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    assign shutdown = ctrl_q[spwoc_pkg::CTRL_SHUTDOWN_BIT];
    assign boot_mode = ctrl_q[spwoc_pkg::CTRL_BOOT_BIT];

    // address decode; the answer comes in the first access cycle
    // core slots from NC up and the rest of page zero answer with an error
    assign setup = psel && !penable;
    assign core_idx = paddr[7:4];
    assign reg_off = paddr[3:0];
    assign core_hit = (paddr[11:8] == 4'h0) && (int'(core_idx) < NC);

    // merge written bytes into a word
    function automatic logic [31:0] spwoc_merge(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res;
    endfunction : spwoc_merge

    // register file next state and bus answer
    // writes commit at the setup edge, so the register already holds the new value
    // in the access cycle while prdata shows the old one; pready answers with no wait state
    always_comb
    begin
        for (int c = 0; c < NC; c++)
        begin
            dir_d[c] = dir_q[c];
            out_d[c] = out_q[c];
        end
        run_d = run_q;
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (setup)
        begin
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            if (core_hit)
            begin
                case (reg_off)
                    spwoc_pkg::OFF_DIR:
                    begin
                        prdata_d = 32'(dir_q[core_idx[2:0]]);
                        if (pwrite)
                        begin
                            dir_d[core_idx[2:0]] = NP'(spwoc_merge(
                                32'(dir_q[core_idx[2:0]]), pwdata, pstrb));
                        end
                    end
                    spwoc_pkg::OFF_OUT:
                    begin
                        prdata_d = 32'(out_q[core_idx[2:0]]);
                        if (pwrite)
                        begin
                            out_d[core_idx[2:0]] = NP'(spwoc_merge(
                                32'(out_q[core_idx[2:0]]), pwdata, pstrb));
                        end
                    end
                    spwoc_pkg::OFF_IN:
                    begin
                        prdata_d = 32'(pins_live);
                        pslverr_d = pwrite;
                    end
                    default:
                    begin
                        pslverr_d = 1'b1;
                    end
                endcase
            end
            // run and ctrl use byte lane 0 only; other lanes are ignored
            else if (paddr == spwoc_pkg::OFF_RUN)
            begin
                prdata_d = 32'(run_q);
                if (pwrite && pstrb[0])
                begin
                    run_d = NC'(pwdata);
                end
            end
            else if (paddr == spwoc_pkg::OFF_CTRL)
            begin
                prdata_d = 32'(ctrl_q);
                if (pwrite && pstrb[0])
                begin
                    ctrl_d = pwdata[1:0];
                end
            end
            else if (paddr == spwoc_pkg::OFF_STAT)
            begin
                prdata_d = 32'(~pin_oe_n_q); // resolved directions
                pslverr_d = pwrite;
            end
            else
            begin
                pslverr_d = 1'b1;
            end
        end
        // a stopped core loses its pin state
        // clearing every cycle also drops writes aimed at a stopped core
        for (int c = 0; c < NC; c++)
        begin
            if (!run_d[c] || ctrl_d[spwoc_pkg::CTRL_SHUTDOWN_BIT])
            begin
                dir_d[c] = '0;
                out_d[c] = '0;
            end
        end
        // shutdown halts every core
        if (ctrl_d[spwoc_pkg::CTRL_SHUTDOWN_BIT])
        begin
            run_d = '0;
        end
    end

    // wired-or of the core collective; registered so it lands one cycle later
    // core_src is same-clock logic and is not synchronised
    always_comb
    begin
        logic [NP-1:0] dir_or;
        logic [NP-1:0] lvl_or;
        logic [NP-1:0] contrib;
        dir_or = '0;
        lvl_or = '0;
        contrib = '0;
        // contrib is rebuilt per core while the two ors accumulate
        for (int c = 0; c < NC; c++)
        begin
            if (run_q[c])
            begin
                dir_or = dir_or | dir_q[c];
                contrib = (out_q[c] | core_src[c*NP +: NP]) & dir_q[c];
                lvl_or = lvl_or | contrib;
            end
        end
        // one means drive; enable is active low
        pin_oe_n_d = ~dir_or;
        pin_o_d = lvl_or;
        // boot loader owns the top four pins until boot completes
        // a plain mux, so the status word shows boot drives too
        if (boot_mode)
        begin
            pin_o_d[spwoc_pkg::BOOT_PIN_LO +: 4] = boot_pin_o;
            pin_oe_n_d[spwoc_pkg::BOOT_PIN_LO +: 4] = boot_pin_oe_n;
        end
        // shutdown overrides boot ownership as well
        if (shutdown)
        begin
            pin_oe_n_d = '1;
            pin_o_d = '0;
        end
    end

    // register file and bus answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int c = 0; c < NC; c++)
            begin
                dir_q[c] <= NP'(spwoc_pkg::DIR_RESET);
                out_q[c] <= NP'(spwoc_pkg::OUT_RESET);
            end
            run_q <= NC'(spwoc_pkg::RUN_RESET);
            ctrl_q <= spwoc_pkg::CTRL_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            for (int c = 0; c < NC; c++)
            begin
                dir_q[c] <= dir_d[c];
                out_q[c] <= out_d[c];
            end
            run_q <= run_d;
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // pin registers; pins come out of reset as inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_o_q <= '0;
            pin_oe_n_q <= '1;
        end
        else
        begin
            pin_o_q <= pin_o_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_o = pin_o_q;
    assign pin_oe_n = pin_oe_n_q;
    assign core_running = run_q;
endmodule : spwoc_top

// [verilog/spwoc_pkg.sv]
// package: register map and constants for the shared pin combiner
package spwoc_pkg;
    localparam int NUM_CORES = 8;
    localparam int NUM_PINS = 32;
    // per core block of 16 bytes: direction, output, input
    localparam logic [11:0] CORE_STRIDE = 12'h010;
    localparam logic [3:0] OFF_DIR = 4'h0;
    localparam logic [3:0] OFF_OUT = 4'h4;
    localparam logic [3:0] OFF_IN = 4'h8;
    // global control registers
    localparam logic [11:0] OFF_RUN = 12'h100;
    localparam logic [11:0] OFF_CTRL = 12'h104;
    localparam logic [11:0] OFF_STAT = 12'h108;
    localparam int CTRL_SHUTDOWN_BIT = 0;
    localparam int CTRL_BOOT_BIT = 1;
    localparam logic [31:0] DIR_RESET = 32'h0000_0000;
    localparam logic [31:0] OUT_RESET = 32'h0000_0000;
    localparam logic [7:0] RUN_RESET = 8'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [3:0] BOOT_PINS = 4'hf;
    localparam int BOOT_PIN_LO = 28;
endpackage : spwoc_pkg

// [verilog/spwoc_sync_if.sv]
// interface: pin levels between the top and the input synchroniser
`timescale 1ns/1ps
interface spwoc_sync_if #(parameter int W = 32);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport top (output raw, input clean);
    modport sync (input raw, output clean);
endinterface : spwoc_sync_if

// [verilog/spwoc_sync.sv]
// module: three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
module spwoc_sync #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin levels
    spwoc_sync_if.sync sif
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] clean_q;
    logic [W-1:0] clean_d;

    // a bit changes only once stages two and three agree
    always_comb
    begin
        clean_d = clean_q;
        for (int i = 0; i < W; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                clean_d[i] = s2_q[i];
            end
        end
    end

    // s1 is only read by s2, never by logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            clean_q <= '0;
        end
        else
        begin
            s1_q <= sif.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            clean_q <= clean_d;
        end
    end

    assign sif.clean = clean_q;
endmodule : spwoc_sync

// [test/spwoc_pin_env.sv]
// model: outside circuitry resolving the shared pin wires
`timescale 1ns/1ps
module spwoc_pin_env (
    // from the combiner
    input wire logic [31:0] pin_o,
    input wire logic [31:0] pin_oe_n,
    // outside drivers, seen only where the pin is an input
    input wire logic [31:0] ext,
    // resolved wire levels
    output logic [31:0] pin_i
);
    // combiner wins where it drives, so no contention is modelled
    assign pin_i = (pin_o & ~pin_oe_n) | (ext & pin_oe_n);
endmodule : spwoc_pin_env

// [test/spwoc_top_sva.sv]
// checker: apb timing and pin relations of the shared pin combiner
`timescale 1ns/1ps
module spwoc_top_sva #(
    parameter int NUM_CORES = 8,
    parameter int NUM_PINS = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and status
    input wire logic [NUM_PINS-1:0] pin_o,
    input wire logic [NUM_PINS-1:0] pin_oe_n,
    input wire logic [NUM_CORES-1:0] core_running
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // steps of a request
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_shut;
        s_setup ##0 pwrite && paddr == 12'h104 && pwdata[1:0] == 2'h1;
    endsequence
    // handshake
    a_zero_wait: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("answer without setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error outside answer");
    a_err_unmapped: assert property (s_setup ##0 paddr >= 12'h10c |=> pslverr)
        else $error("unmapped access accepted");
    a_ro_input: assert property (s_setup ##0 pwrite && paddr < 12'h080
        && paddr[3:0] == 4'h8 |=> pslverr)
        else $error("input register write accepted");
    // pin relations: idle cores drive nothing, shutdown frees all pins
    a_stop_idle: assert property (core_running == '0 [*3]
        |=> pin_oe_n[27:0] == 28'hfffffff)
        else $error("stopped cores still drive");
    a_shut_pins: assert property (s_shut |-> ##[1:3] (&pin_oe_n && core_running == '0))
        else $error("shutdown left pins driven");
    // status read gives resolved direction while it is steady
    a_stat_read: assert property (s_setup ##0 !pwrite && paddr == 12'h108
        ##1 $stable(pin_oe_n) |-> prdata == ~pin_oe_n)
        else $error("status differs from pin direction");
endmodule : spwoc_top_sva
bind spwoc_top spwoc_top_sva #(.NUM_CORES(NUM_CORES), .NUM_PINS(NUM_PINS)) spwoc_top_sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .core_running(core_running));

// [test/test_spwoc_top.sv]
// bench: shared pin combiner against a behavioural register and pin model
`timescale 1ns/1ps
module test_spwoc_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, ext = 32'h0, rd, prdata, pin_i, pin_o, pin_oe_n, e_oe_n, e_o;
    logic [3:0] pstrb = 4'h0, boot_o = 4'h0, boot_oe_n = 4'hf;
    logic [255:0] core_src = '0;
    logic [7:0] core_running, m_run = 8'h0;
    logic [1:0] m_ctrl = 2'h0;
    logic [31:0] m_dir [8] = '{default: 32'h0};
    logic [31:0] m_out [8] = '{default: 32'h0};
    int n_errors = 0, checks_done = 0, cycles = 0;
    spwoc_top spwoc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_src(core_src), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .boot_pin_o(boot_o), .boot_pin_oe_n(boot_oe_n),
        .core_running(core_running));
    spwoc_pin_env spwoc_pin_env_i (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext(ext), .pin_i(pin_i));
    initial forever #12.5 pclk = ~pclk;
    // hang guard, well above the fewer than one thousand cycles the run needs
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_err(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp}, "slave error");
    endtask : chk_err
    // apb master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // write and update the model; stopped cores drop their writes
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        int c;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        c = a[6:4];
        apb(1'b1, a, d, s);
        if (a < 12'h080 && m_run[c] && a[3:0] == 4'h0) m_dir[c] = (m_dir[c] & ~m) | (d & m);
        if (a < 12'h080 && m_run[c] && a[3:0] == 4'h4) m_out[c] = (m_out[c] & ~m) | (d & m);
        if (a == 12'h100) m_run = d[7:0];
        if (a == 12'h104) m_ctrl = d[1:0];
        if (m_ctrl[0]) m_run = 8'h0;
        for (int k = 0; k < 8; k++) if (!m_run[k]) {m_dir[k], m_out[k]} = 64'h0;
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0, 4'h0);
        if (!e) chk(rd, exp, "read data");
        chk_err(er, e);
    endtask : rdc
    // wired-or of the model, checked one cycle after the write completes
    task automatic pins();
        logic [31:0] d;
        logic [31:0] o;
        {d, o} = 64'h0;
        for (int c = 0; c < 8; c++) d = d | m_dir[c];
        for (int c = 0; c < 8; c++) o = o | ((m_out[c] | core_src[c*32+:32]) & m_dir[c]);
        if (m_ctrl[1]) {d[31:28], o[31:28]} = {~boot_oe_n, boot_o};
        if (m_ctrl[0]) d = 32'h0;
        e_oe_n = ~d;
        e_o = o & d;
        @(posedge pclk);
        chk(pin_oe_n, e_oe_n, "pin direction");
        chk(pin_o & ~pin_oe_n, e_o, "pin level");
        chk({24'h0, core_running}, {24'h0, m_run}, "running cores");
    endtask : pins
    initial
    begin
        void'($urandom(32'hf709));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int c = 0; c < 8; c++) rdc(12'(c * 16), 32'h0, 1'b0);
        pins();
        for (int r = 0; r < 6; r++)
        begin
            for (int c = 0; c < 8; c++) core_src[c*32+:32] <= $urandom;
            {ext, boot_o, boot_oe_n} <= {$urandom, 4'($urandom), 4'($urandom)};
            wr(12'h100, {24'h0, 8'($urandom) | 8'h03}, 4'hf);
            wr(12'h104, {30'h0, r[0], 1'b0}, 4'hf);
            for (int c = 0; c < 8; c++) wr(12'(c * 16), $urandom, 4'($urandom));
            for (int c = 0; c < 8; c++) wr(12'(c * 16 + 4), $urandom, 4'hf);
            pins();
            for (int c = 0; c < 8; c++) rdc(12'(c * 16), m_dir[c], 1'b0);
            for (int c = 0; c < 8; c++) rdc(12'(c * 16 + 4), m_out[c], 1'b0);
            repeat (8) @(posedge pclk);
            rdc(12'(r * 16 + 8), (e_o & ~e_oe_n) | (ext & e_oe_n), 1'b0);
            rdc(12'h108, ~e_oe_n, 1'b0);
        end
        apb(1'b1, 12'h018, 32'hffffffff, 4'hf);
        chk({31'h0, er}, 32'h1, "input write error");
        rdc(12'h200, 32'h0, 1'b1);
        rdc(12'h00c, 32'h0, 1'b1);
        pins();
        wr(12'h104, 32'h1, 4'hf);
        pins();
        print_verdict();
    end
endmodule : test_spwoc_top
